/* bench/omc_host_model.sv */
// Purpose: Host and supply monitor facing the mode controller
// Assumes: Requests change just after a rising edge
// Notes: Pin follows request; the host holds it itself
`timescale 1ns/1ps
`default_nettype none
module omc_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests from the bench
  input wire logic i_supply_req,
  input wire logic i_above_req,
  input wire logic i_pon_req,
  // Lines into the device
  output logic o_supply,
  output logic o_above,
  output logic o_pin
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_supply <= 1'b0;
      o_above <= 1'b0;
      o_pin <= 1'b0;
    end else begin
      o_supply <= i_supply_req;
      // No level report without supply present
      o_above <= i_supply_req & i_above_req;
      o_pin <= i_pon_req;
    end
  end
endmodule
`default_nettype wire

/* bench/omc_monitor.sv */
// Purpose: Mode and clock selection properties
// Assumes: One clock domain
// Notes: Bound to omc_top
`timescale 1ns/1ps
`default_nettype none
module omc_monitor (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_SUPPLY_PRESENT,
  input wire logic [4:0] O_MODE,
  input wire logic O_PSAVE_ENABLED,
  input wire logic O_SEL_LF_REF,
  input wire logic O_SEL_HF_REF,
  input wire logic O_IF_ACCESSIBLE,
  input wire logic O_WAKE_DETECT_EN
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  wire logic m_np = O_MODE == omc_pkg::OMC_NOT_POWERED;
  wire logic m_off = O_MODE == omc_pkg::OMC_POWER_OFF;
  wire logic m_idle = O_MODE == omc_pkg::OMC_IDLE;
  wire logic m_act = O_MODE == omc_pkg::OMC_ACTIVE;
  wire logic m_run = m_act || O_MODE == omc_pkg::OMC_CONNECTED;
  sequence s_idle_leave; m_idle ##1 !m_idle; endsequence
  sequence s_np_leave; m_np ##1 !m_np; endsequence
  sequence s_idle_entry; m_act ##1 m_idle; endsequence
  sequence s_off_leave; m_off ##1 !m_off; endsequence
  property p_idle_exit;
    s_idle_leave |-> m_act || m_np || m_off;
  endproperty
  property p_off_exit;
    s_off_leave |-> m_act || m_np;
  endproperty
  property p_lf_idle;
    m_idle |-> O_SEL_LF_REF && !O_SEL_HF_REF;
  endproperty
  property p_run_outs;
    m_run |-> O_SEL_HF_REF && !O_SEL_LF_REF && O_IF_ACCESSIBLE &&
      !O_WAKE_DETECT_EN;
  endproperty
  property p_off_outs;
    (m_np || m_off) |-> !O_IF_ACCESSIBLE && !O_SEL_HF_REF && !O_SEL_LF_REF;
  endproperty
  property p_idle_outs;
    m_idle |-> !O_IF_ACCESSIBLE && O_WAKE_DETECT_EN;
  endproperty
  // Enable is cleared one cycle into power-off and shown one cycle later
  property p_psave_off;
    m_off [*3] |-> !O_PSAVE_ENABLED;
  endproperty
  // Shown enable lags the internal one that allowed the entry by a cycle
  property p_idle_psave;
    s_idle_entry |-> O_PSAVE_ENABLED;
  endproperty
  a_idle_no_jump: assert property (p_idle_exit)
    else $error("idle left to connected");
  a_np_to_off: assert property (s_np_leave |-> m_off)
    else $error("not-powered left to a wrong mode");
  a_off_exit: assert property (p_off_exit)
    else $error("power-off left to a wrong mode");
  a_supply_loss: assert property (!I_SUPPLY_PRESENT [*4] |-> m_np)
    else $error("mode kept without supply");
  a_lf_idle: assert property (p_lf_idle)
    else $error("idle not on low reference");
  a_hf_run: assert property (p_run_outs)
    else $error("run mode outputs wrong");
  a_if_closed: assert property (p_off_outs)
    else $error("interfaces open while off");
  a_idle_suspend: assert property (p_idle_outs)
    else $error("idle interfaces not suspended");
  a_psave_off: assert property (p_psave_off)
    else $error("power saving kept while off");
  a_idle_needs_psave: assert property (p_idle_psave)
    else $error("idle entered without power saving");
endmodule
bind omc_top omc_monitor mon_u (.I_MCLK, .I_RESET, .I_SUPPLY_PRESENT, .O_MODE,
  .O_PSAVE_ENABLED, .O_SEL_LF_REF, .O_SEL_HF_REF, .O_IF_ACCESSIBLE,
  .O_WAKE_DETECT_EN);
`default_nettype wire

/* bench/tb_omc_top.sv */
// Purpose: Self-checking bench of the mode controller
// Assumes: Idle wakes wait up to three slow ticks
// Notes: Row bits 13..0 supply,above,pin,off,set,clr,net,if,api,act,cs,rp,tb,ct
`timescale 1ns/1ps
`default_nettype none
module tb_omc_top;
  typedef struct packed { logic [13:0] vec; logic [4:0] mode; } omc_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] vec = 14'h0000;
  logic sup, abv, pin, psave, lf, hf, ifa, wde;
  logic [4:0] mode;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  omc_row_s rows [27] = '{
    {14'h2000, 5'h02}, {14'h3800, 5'h08},
    {14'h300A, 5'h10}, {14'h3003, 5'h08},
    {14'h3200, 5'h04}, {14'h3280, 5'h08},
    {14'h3200, 5'h04}, {14'h3240, 5'h08},
    {14'h3200, 5'h04}, {14'h3220, 5'h08},
    {14'h3200, 5'h04}, {14'h3206, 5'h10},
    {14'h3200, 5'h04}, {14'h3280, 5'h08},
    {14'h3290, 5'h08}, {14'h3210, 5'h08},
    {14'h3300, 5'h04}, {14'h3100, 5'h08},
    {14'h3280, 5'h08},
    {14'h3680, 5'h02}, {14'h2800, 5'h02},
    {14'h3800, 5'h08}, {14'h380A, 5'h10},
    {14'h080A, 5'h01}, {14'h0800, 5'h01},
    {14'h2000, 5'h02}, {14'h3800, 5'h08}};
  omc_host_model model_u (.i_clk(clk), .i_rst(rst), .i_supply_req(vec[13]),
    .i_above_req(vec[12]), .i_pon_req(vec[11]), .o_supply(sup),
    .o_above(abv), .o_pin(pin));
  omc_top dut_u (.I_MCLK(clk), .I_RESET(rst), .I_SUPPLY_PRESENT(sup),
    .I_SUPPLY_ABOVE_MIN(abv), .I_POWER_ON_REQUEST_PIN(pin),
    .I_POWER_OFF_EVENT(vec[10]), .I_PSAVE_SET(vec[9]), .I_PSAVE_CLEAR(vec[8]),
    .I_WAKE_NETWORK(vec[7]), .I_WAKE_INTERFACE(vec[6]), .I_WAKE_API(vec[5]),
    .I_ACTIVITY_BUSY(vec[4]), .I_CONN_START(vec[3]), .I_RADIO_PENDING(vec[2]),
    .I_TRAFFIC_BUSY(vec[1]), .I_CONN_TERMINATE(vec[0]), .O_MODE(mode),
    .O_PSAVE_ENABLED(psave), .O_SEL_LF_REF(lf), .O_SEL_HF_REF(hf),
    .O_IF_ACCESSIBLE(ifa), .O_WAKE_DETECT_EN(wde));
  initial forever #20 clk = ~clk;
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle samples non-supply inputs only on the slow tick, so the wait bound covers three ticks
  task automatic apply(input omc_row_s r);
    int n;
    n = 0;
    @(posedge clk) vec <= r.vec;
    repeat (8) @(posedge clk);
    @(negedge clk);
    while (mode !== r.mode && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(mode, r.mode);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apply(rows[i]);
      $display("Row %0d done", i);
    end
    repeat (2000) @(posedge clk);
    @(negedge clk);
    check(mode, 5'h08);
    check({4'h0, psave}, 5'h00);
    apply('{14'h2000, 5'h02});
    $display("Default and low supply tests done");
    @(posedge clk) rst <= 1'b1;
    @(negedge clk);
    check(mode, 5'h01);
    check({lf, hf, ifa, wde, psave}, 5'h00);
    $display("Reset test done");
    @(posedge clk) rst <= 1'b0;
    apply('{14'h2000, 5'h02});
    $display("Reset release test done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* rtl/omc_pkg.sv */
// Purpose: Shared constants and state type of the operating mode controller
// Assumes: Single 25 MHz clock domain
// Notes: State codes are one-hot
package omc_pkg;

  typedef enum logic [4:0] {
    OMC_NOT_POWERED = 5'h01,
    OMC_POWER_OFF   = 5'h02,
    OMC_IDLE        = 5'h04,
    OMC_ACTIVE      = 5'h08,
    OMC_CONNECTED   = 5'h10
  } omc_state_e;

  // Reset values
  localparam logic OMC_PSAVE_RST = 1'b0;
  localparam logic OMC_LF_DIV_TICK_RST = 1'b0;

  // Clock rates
  localparam int OMC_MCLK_HZ = 25000000;
  localparam int OMC_LF_REF_HZ = 32000;
  localparam int OMC_HF_REF_HZ = 26000000;
  // Divider count for the low-frequency reference enable (rounded down)
  localparam int OMC_LF_DIV = OMC_MCLK_HZ / OMC_LF_REF_HZ;
  localparam logic [9:0] OMC_LF_DIV_LAST = 10'(OMC_LF_DIV - 1);

  // Synchroniser depth
  localparam int OMC_SYNC_STAGES = 2;

endpackage

/* rtl/omc_sync.sv */
// Purpose: Two-stage synchroniser for one level input, advanced by an enable
// Assumes: Enable is held high, or is a one-cycle pulse at the slow reference rate
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module omc_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else if (i_en) begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* rtl/omc_top.sv */
// Purpose: Operating mode state machine with reference clock selection
// Assumes: All inputs synchronous to I_MCLK; I_RESET only at bring-up
// Notes: Non-supply inputs are resampled at the slow reference in idle, every cycle otherwise
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Not-powered moves to power-off once supply becomes present.
// - Not-powered never switches on from supply or power-on pin.
// - Supply removal forces not-powered from any state.
// - Power-off enters active on a power-on pin request.
// - Valid power-off event while active shuts down to power-off.
// - Power saving enabled: active drops to idle when no activity.
// - Idle returns to active on network, interface or API wake.
// - Power saving disabled after power-on until explicitly enabled.
// - Active goes connected on connection start or pending radio need.
// - No traffic: connected returns to active, then idle if enabled.
// - Idle never goes straight to connected; passes through active.
// - Data connection termination returns connected to active.
// - Idle clocks the core from the 32 kHz reference.
// - Active and connected clock the core from 26 MHz reference.
// - Not-powered and power-off keep application interfaces closed.
// - Idle suspends interfaces; only wake detection stays effective.
// - Power-on accepted only while supply is above extended minimum.
// - Device may switch off when supply drops below extended minimum.
module omc_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Supply monitor
  input wire logic I_SUPPLY_PRESENT,
  input wire logic I_SUPPLY_ABOVE_MIN,
  // Host requests
  input wire logic I_POWER_ON_REQUEST_PIN,
  input wire logic I_POWER_OFF_EVENT,
  input wire logic I_PSAVE_SET,
  input wire logic I_PSAVE_CLEAR,
  // Wake and activity sources
  input wire logic I_WAKE_NETWORK,
  input wire logic I_WAKE_INTERFACE,
  input wire logic I_WAKE_API,
  input wire logic I_ACTIVITY_BUSY,
  input wire logic I_CONN_START,
  input wire logic I_RADIO_PENDING,
  input wire logic I_TRAFFIC_BUSY,
  input wire logic I_CONN_TERMINATE,
  // Mode and clock outputs
  output logic [4:0] O_MODE,
  output logic O_PSAVE_ENABLED,
  output logic O_SEL_LF_REF,
  output logic O_SEL_HF_REF,
  output logic O_IF_ACCESSIBLE,
  output logic O_WAKE_DETECT_EN
);
  localparam int NSYNC = 14;

  omc_pkg::omc_state_e state_reg;
  omc_pkg::omc_state_e state_next;
  logic psave_reg;
  logic [9:0] lf_cnt_reg;
  logic lf_tick_reg;
  logic sync_en;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  // Synchronised copies, one per bit of raw_in
  logic s_sup;
  logic s_above;
  logic s_pon;
  logic s_poff;
  logic s_pset;
  logic s_pclr;
  logic s_wnet;
  logic s_wif;
  logic s_wapi;
  logic s_busy;
  logic s_cstart;
  logic s_rpend;
  logic s_traffic;
  logic s_cterm;
  logic wake_any;
  logic radio_need;
  logic off_req;
  logic idle_ok;
  logic lf_next;
  logic hf_next;
  logic ifa_next;
  logic wde_next;

  // Divider giving the low-frequency reference enable
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      lf_cnt_reg <= 10'h000;
      lf_tick_reg <= omc_pkg::OMC_LF_DIV_TICK_RST;
    end else if (lf_cnt_reg == omc_pkg::OMC_LF_DIV_LAST) begin
      lf_cnt_reg <= 10'h000;
      lf_tick_reg <= 1'b1;
    end else begin
      lf_cnt_reg <= lf_cnt_reg + 10'h001;
      lf_tick_reg <= 1'b0;
    end
  end

  // Idle samples at the slow reference, other states every cycle; the
  // supply inputs always use full rate so loss is never missed
  assign sync_en = (state_reg == omc_pkg::OMC_IDLE) ? lf_tick_reg : 1'b1;

  // Supply bits sit at index 0 and 1, the only full-rate stages in idle
  assign raw_in = {
    I_CONN_TERMINATE,
    I_TRAFFIC_BUSY,
    I_RADIO_PENDING,
    I_CONN_START,
    I_ACTIVITY_BUSY,
    I_WAKE_API,
    I_WAKE_INTERFACE,
    I_WAKE_NETWORK,
    I_PSAVE_CLEAR,
    I_PSAVE_SET,
    I_POWER_OFF_EVENT,
    I_POWER_ON_REQUEST_PIN,
    I_SUPPLY_ABOVE_MIN,
    I_SUPPLY_PRESENT
  };

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      omc_sync u_sync (
        .i_clk(I_MCLK),
        .i_rst(I_RESET),
        .i_en((gi < 2) ? 1'b1 : sync_en),
        .i_d(raw_in[gi]),
        .o_q(syn[gi])
      );
    end
  endgenerate

  assign s_sup = syn[0];
  assign s_above = syn[1];
  assign s_pon = syn[2];
  assign s_poff = syn[3];
  assign s_pset = syn[4];
  assign s_pclr = syn[5];
  assign s_wnet = syn[6];
  assign s_wif = syn[7];
  assign s_wapi = syn[8];
  assign s_busy = syn[9];
  assign s_cstart = syn[10];
  assign s_rpend = syn[11];
  assign s_traffic = syn[12];
  assign s_cterm = syn[13];

  assign wake_any = s_wnet | s_wif | s_wapi;
  assign radio_need = s_cstart | s_rpend;

  // Shutdown request: a power-off event, or supply under the extended
  // minimum, which lets the device switch itself off
  assign off_req = s_poff | ~s_above;
  // Idle only when power saving is on and nothing keeps the core busy
  assign idle_ok = psave_reg & ~s_busy & ~wake_any;

  // Power saving enable: cleared on every power-up, set only on request
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      psave_reg <= omc_pkg::OMC_PSAVE_RST;
    end else if (state_reg == omc_pkg::OMC_NOT_POWERED ||
                 state_reg == omc_pkg::OMC_POWER_OFF) begin
      psave_reg <= 1'b0;
    end else if (s_pset) begin
      psave_reg <= 1'b1;
    end else if (s_pclr) begin
      psave_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (!s_sup) begin
      state_next = omc_pkg::OMC_NOT_POWERED;
    end else begin
      case (state_reg)
        omc_pkg::OMC_NOT_POWERED: begin
          // Pin is ignored here; only supply arrival moves on
          state_next = omc_pkg::OMC_POWER_OFF;
        end
        omc_pkg::OMC_POWER_OFF: begin
          if (s_pon && s_above) begin
            state_next = omc_pkg::OMC_ACTIVE;
          end
        end
        omc_pkg::OMC_ACTIVE: begin
          if (off_req) begin
            state_next = omc_pkg::OMC_POWER_OFF;
          end else if (radio_need) begin
            state_next = omc_pkg::OMC_CONNECTED;
          end else if (idle_ok) begin
            state_next = omc_pkg::OMC_IDLE;
          end
        end
        omc_pkg::OMC_IDLE: begin
          if (off_req) begin
            state_next = omc_pkg::OMC_POWER_OFF;
          end else if (wake_any || radio_need || !psave_reg) begin
            // Radio need lands in active first
            state_next = omc_pkg::OMC_ACTIVE;
          end
        end
        omc_pkg::OMC_CONNECTED: begin
          if (off_req) begin
            state_next = omc_pkg::OMC_POWER_OFF;
          end else if (s_cterm || !s_traffic) begin
            state_next = omc_pkg::OMC_ACTIVE;
          end
        end
        default: begin
          state_next = omc_pkg::OMC_NOT_POWERED;
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= omc_pkg::OMC_NOT_POWERED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Next-state views, so each output register holds one concern
  always_comb begin
    lf_next = 1'b0;
    hf_next = 1'b0;
    ifa_next = 1'b0;
    wde_next = 1'b0;
    case (state_next)
      omc_pkg::OMC_IDLE: begin
        lf_next = 1'b1;
        // Interfaces stay suspended, wake detection stays armed
        wde_next = 1'b1;
      end
      omc_pkg::OMC_ACTIVE, omc_pkg::OMC_CONNECTED: begin
        hf_next = 1'b1;
        ifa_next = 1'b1;
      end
      default: begin
        // Switched off: no clock selected and interfaces closed
        ifa_next = 1'b0;
      end
    endcase
  end

  // Mode and clock outputs registered from the next state so they track state_reg exactly
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_MODE <= omc_pkg::OMC_NOT_POWERED;
    end else begin
      O_MODE <= state_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SEL_LF_REF <= 1'b0;
    end else begin
      O_SEL_LF_REF <= lf_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SEL_HF_REF <= 1'b0;
    end else begin
      O_SEL_HF_REF <= hf_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_IF_ACCESSIBLE <= 1'b0;
    end else begin
      O_IF_ACCESSIBLE <= ifa_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WAKE_DETECT_EN <= 1'b0;
    end else begin
      O_WAKE_DETECT_EN <= wde_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_PSAVE_ENABLED <= omc_pkg::OMC_PSAVE_RST;
    end else begin
      O_PSAVE_ENABLED <= psave_reg;
    end
  end

endmodule
`default_nettype wire
